// ==== hw/i2m_map.svh ====
/*
 Register indices, field positions, reset values and timing counts of the
 two-wire master. Byte address on the register bus is four times an index.
 Assumes inclusion by bare name from the design file.
*/
`ifndef I2M_MAP_SVH
`define I2M_MAP_SVH
`define I2M_IDX_TX 8'h9A
`define I2M_IDX_RX 8'h9B
`define I2M_IDX_MODE 8'hE8
`define I2M_IDX_ADDR 8'hE9
`define I2M_IDX_STAT 8'hEA
`define I2M_IDX_MASK 8'hEB
`define I2M_BIT_EN 7
`define I2M_DIV_MSB 6
`define I2M_DIV_LSB 5
`define I2M_RCT_MSB 4
`define I2M_BIT_BUSY 7
`define I2M_BIT_NOACK 6
`define I2M_BIT_RXP 5
`define I2M_BIT_TXE 4
`define I2M_BIT_ACC 1
`define I2M_BIT_TXW 0
`define I2M_STICKY_MASK 8'h73
`define I2M_RST_REG 8'h00
`define I2M_FIFO_FULL 3'h4
`define I2M_LVL_EMPTY 2'h0
`define I2M_LVL_HALF 2'h2
`define I2M_LVL_FULL 2'h3
`define I2M_QTR_BASE 6'h04
`define I2M_RESP_OKAY 2'h0
`define I2M_RESP_SLVERR 2'h2
`endif

// ==== hw/i2m_pkg.sv ====
/*
 Types shared by the two-wire master.
 Assumes nothing of its surroundings.
*/
package i2m_pkg;
	// Sequencer states, Gray coded in declaration order.
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h0,
		ST_START = 4'h1,
		ST_ADDR = 4'h3,
		ST_ACK_A = 4'h2,
		ST_TXB = 4'h6,
		ST_ACK_T = 4'h7,
		ST_RXB = 4'h5,
		ST_ACK_M = 4'h4,
		ST_STOP = 4'hC,
		ST_RSTART = 4'hD
	} i2m_state_t;
endpackage

// ==== hw/i2m_top.sv ====
/*
 Two-wire bus master with target address register, status flags, four-byte
 transmit and receive FIFOs and an AXI4-Lite register slave.
 Assumes a single 125 MHz clock, an external pull-up on both bus lines and
 one AXI4-Lite master issuing one write and one read at a time.
*/
`include "i2m_map.svh"

// Operation
// - Address register write starts a transaction.
// - Bit 0 selects read or write command.
// - Data bytes pass through separate transmit and receive buffers.
// - Busy flag set; transmit FIFO drained meanwhile.
// - Missing acknowledge flags and stops transfer.
// - Receive flag set while receive FIFO nonempty.
// - Transmit flag set while transmit FIFO empty.
// - Writing zero clears the sticky flags.
// - Active FIFO level shown in bits 3:2.
// - Simultaneous FIFO write and read flags error.
// - Write into full transmit FIFO flags error.
// - Master acknowledges each received byte before the last automatically.
// - Master sends NACK on byte count plus one.
// - Address rewrite mid-transfer gives repeated start.
// - Enable bit gates only the launch of a transaction.
// - Read stops after count plus one, or error.
// - Serial clock from core divided 16..128.
// - Four-byte receive and transmit FIFOs.
module i2m_top
	import i2m_pkg::*;
(
	input wire logic CLK, // Core clock.
	input wire logic RST, // Asynchronous reset, active high.
	input wire logic [11:0] AWADDR, // Write address.
	input wire logic AWVALID, // Write address valid.
	output logic AWREADY, // Write address ready.
	input wire logic [31:0] WDATA, // Write data.
	input wire logic [3:0] WSTRB, // Write byte strobes.
	input wire logic WVALID, // Write data valid.
	output logic WREADY, // Write data ready.
	output logic [1:0] BRESP, // Write response code.
	output logic BVALID, // Write response valid.
	input wire logic BREADY, // Write response ready.
	input wire logic [11:0] ARADDR, // Read address.
	input wire logic ARVALID, // Read address valid.
	output logic ARREADY, // Read address ready.
	output logic [31:0] RDATA, // Read data.
	output logic [1:0] RRESP, // Read response code.
	output logic RVALID, // Read data valid.
	input wire logic RREADY, // Read data ready.
	output logic IRQ, // Level interrupt, active high.
	input wire logic SDA_IN, // Data line level.
	output logic SDA_OUT, // Data line drive value, always low.
	output logic SDA_OE_N, // Data line enable, low while pulling low.
	input wire logic SCL_IN, // Clock line level.
	output logic SCL_OUT, // Clock line drive value, always low.
	output logic SCL_OE_N // Clock line enable, low while pulling low.
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic aw_held; // Write address captured.
	logic w_held; // Write data captured.
	logic [11:0] aw_addr; // Captured write address.
	logic [7:0] w_byte; // Captured low data byte.
	logic w_lane; // Captured strobe of byte lane 0.
	logic wr_go; // Register write commits this cycle.
	logic rd_go; // Register read is taken this cycle.
	logic [7:0] wr_idx; // Register index of the write.
	logic [7:0] rd_idx; // Register index of the read.
	logic [7:0] mode; // Mode register.
	logic [7:0] addr_reg; // Target address and direction register.
	logic [7:0] mask; // Interrupt mask register.
	logic [7:0] flag; // Sticky status flags.
	logic [7:0] set_vec; // Flag set events.
	logic [7:0] clr_vec; // Flag clear requests.
	logic [7:0] sticky_bits; // Which status bits are sticky flags.
	logic [7:0] stat_rd; // Status register read value.
	logic [1:0] level; // Level of the active FIFO.
	logic [7:0] tx_mem [4]; // Transmit FIFO storage.
	logic [7:0] rx_mem [4]; // Receive FIFO storage.
	logic [1:0] tx_wp, tx_rp, rx_wp, rx_rp; // FIFO pointers.
	logic [2:0] tx_cnt, rx_cnt; // FIFO fill counts.
	logic tx_push, tx_pop, tx_flush, rx_push, rx_pop; // FIFO strobes.
	logic tx_try; // Software writes the transmit buffer.
	logic acc_ev; // Simultaneous buffer write and read.
	logic pending; // Transaction launch requested.
	logic take_pend; // Launch request consumed this cycle.
	i2m_state_t state; // Sequencer state.
	logic [7:0] work_addr; // Address byte of the running transaction.
	logic [7:0] shreg; // Shift register.
	logic [2:0] bitn; // Bit counter inside a byte.
	logic [1:0] q; // Quarter of the bit period.
	logic [5:0] div_cnt; // Quarter period divider.
	logic [5:0] quarter; // Quarter period length.
	logic adv; // Quarter step enable.
	logic ack_bit; // Sampled acknowledge level, high means none.
	logic [5:0] rx_got; // Bytes received in this transaction.
	logic last; // Current received byte is the final one.
	logic fin_ok; // Normal end of the transaction at this step.
	logic scl_low, sda_low; // Line pull-down requests.
	logic [2:0] sync [2]; // Input synchronisers, data then clock.
	logic [1:0] line_s; // Filtered line levels.
	logic sda_s, scl_s; // Filtered data and clock levels.

	// Known register index check, used by both the write and read paths.
	function automatic logic is_mapped(input logic [11:0] a);
		logic [7:0] i;
		i = a[9:2];
		is_mapped = (a[11:10] == 2'h0) && ((i == `I2M_IDX_TX) || (i == `I2M_IDX_RX) ||
			(i == `I2M_IDX_MODE) || (i == `I2M_IDX_ADDR) || (i == `I2M_IDX_STAT) ||
			(i == `I2M_IDX_MASK));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	assign AWREADY = !aw_held;
	assign WREADY = !w_held;
	assign ARREADY = !RVALID;
	assign wr_go = aw_held && w_held && !BVALID;
	assign rd_go = ARVALID && !RVALID;
	assign wr_idx = aw_addr[9:2];
	assign rd_idx = ARADDR[9:2];

	// Address and data are captured independently, in either order.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (WVALID && WREADY)
			begin
				w_held <= 1'b1;
				w_byte <= WDATA[7:0];
				w_lane <= WSTRB[0];
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	// Write response follows the commit by one cycle.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			BVALID <= 1'b0;
			BRESP <= `I2M_RESP_OKAY;
		end
		else if (wr_go)
		begin
			BVALID <= 1'b1;
			BRESP <= is_mapped(aw_addr) ? `I2M_RESP_OKAY : `I2M_RESP_SLVERR;
		end
		else if (BREADY)
			BVALID <= 1'b0;
	end

	// Read data is registered; unmapped indices answer zero with an error.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `I2M_RESP_OKAY;
		end
		else if (rd_go)
		begin
			RVALID <= 1'b1;
			RRESP <= is_mapped(ARADDR) ? `I2M_RESP_OKAY : `I2M_RESP_SLVERR;
			RDATA <= 32'h0000_0000;
			if (is_mapped(ARADDR))
			begin
				unique case (rd_idx)
					`I2M_IDX_RX: RDATA[7:0] <= (rx_cnt != 3'h0) ? rx_mem[rx_rp] : 8'h00;
					`I2M_IDX_MODE: RDATA[7:0] <= mode;
					`I2M_IDX_ADDR: RDATA[7:0] <= addr_reg;
					`I2M_IDX_STAT: RDATA[7:0] <= stat_rd;
					`I2M_IDX_MASK: RDATA[7:0] <= mask;
					default: RDATA[7:0] <= 8'h00;
				endcase
			end
		end
		else if (RREADY)
			RVALID <= 1'b0;
	end

	// Control registers written by software.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			mode <= `I2M_RST_REG;
			addr_reg <= `I2M_RST_REG;
			mask <= `I2M_RST_REG;
		end
		else if (wr_go && w_lane && is_mapped(aw_addr))
		begin
			if (wr_idx == `I2M_IDX_MODE)
				mode <= w_byte;
			if (wr_idx == `I2M_IDX_ADDR)
				addr_reg <= w_byte;
			if (wr_idx == `I2M_IDX_MASK)
				mask <= w_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFOs between software and the shift register.

	assign tx_try = wr_go && w_lane && is_mapped(aw_addr) && (wr_idx == `I2M_IDX_TX);
	assign tx_push = tx_try && (tx_cnt != `I2M_FIFO_FULL);
	assign rx_pop = rd_go && is_mapped(ARADDR) && (rd_idx == `I2M_IDX_RX) && (rx_cnt != 3'h0);
	assign acc_ev = tx_try && rd_go && is_mapped(ARADDR) && (rd_idx == `I2M_IDX_RX);

	// Transmit FIFO: filled by software, drained by the sequencer.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			tx_wp <= 2'h0;
			tx_rp <= 2'h0;
			tx_cnt <= 3'h0;
		end
		else
		begin
			if (tx_push)
			begin
				tx_mem[tx_wp] <= w_byte;
				tx_wp <= tx_wp + 2'h1;
			end
			if (tx_flush)
			begin
				tx_rp <= tx_push ? tx_wp : tx_wp + 2'h0;
				tx_cnt <= tx_push ? 3'h1 : 3'h0;
			end
			else
			begin
				if (tx_pop)
					tx_rp <= tx_rp + 2'h1;
				tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop};
			end
		end
	end

	// Receive FIFO: filled by the sequencer, drained by register reads.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			rx_wp <= 2'h0;
			rx_rp <= 2'h0;
			rx_cnt <= 3'h0;
		end
		else
		begin
			if (rx_push && (rx_cnt != `I2M_FIFO_FULL))
			begin
				rx_mem[rx_wp] <= shreg;
				rx_wp <= rx_wp + 2'h1;
			end
			if (rx_pop)
				rx_rp <= rx_rp + 2'h1;
			rx_cnt <= rx_cnt + {2'h0, rx_push && (rx_cnt != `I2M_FIFO_FULL)} - {2'h0, rx_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags and interrupt.

	always_comb
	begin
		set_vec = 8'h00;
		set_vec[`I2M_BIT_NOACK] = tx_flush;
		set_vec[`I2M_BIT_RXP] = (rx_cnt != 3'h0);
		set_vec[`I2M_BIT_TXE] = (tx_cnt == 3'h0);
		set_vec[`I2M_BIT_ACC] = acc_ev;
		set_vec[`I2M_BIT_TXW] = tx_try && (tx_cnt == `I2M_FIFO_FULL);
	end

	// Zero written to a sticky bit clears it; a same-cycle event wins.
	assign clr_vec = (wr_go && w_lane && is_mapped(aw_addr) && (wr_idx == `I2M_IDX_STAT)) ?
		(~w_byte & `I2M_STICKY_MASK) : 8'h00;

	// The sticky layout as a signal, so that single bits can be picked out of it.
	assign sticky_bits = `I2M_STICKY_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_flag
			// One sticky status bit.
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
					flag[gi] <= 1'b0;
				else
					flag[gi] <= (set_vec[gi] | (flag[gi] & ~clr_vec[gi])) &
						sticky_bits[gi];
			end
		end
	endgenerate

	// Level of whichever FIFO the current direction uses.
	always_comb
	begin
		logic [2:0] c;
		c = work_addr[0] ? rx_cnt : tx_cnt;
		if (c == 3'h0)
			level = `I2M_LVL_EMPTY;
		else if (c == `I2M_FIFO_FULL)
			level = `I2M_LVL_FULL;
		else
			level = `I2M_LVL_HALF;
	end

	assign stat_rd = {state != ST_IDLE, flag[6:4], level, flag[1:0]};
	assign IRQ = |(flag & mask);

	////////////////////////////////////////////////////////////////////////////
	// Line synchronisers and drivers.

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			// Three stages; a level counts once stages two and three agree.
			always_ff @(posedge CLK or posedge RST)
			begin
				if (RST)
				begin
					sync[gi] <= 3'h7;
					line_s[gi] <= 1'b1;
				end
				else
				begin
					sync[gi] <= {sync[gi][1:0], (gi == 0) ? SDA_IN : SCL_IN};
					if (sync[gi][1] == sync[gi][2])
						line_s[gi] <= sync[gi][2];
				end
			end
		end
	endgenerate

	assign sda_s = line_s[0];
	assign scl_s = line_s[1];
	assign SDA_OUT = 1'b0;
	assign SCL_OUT = 1'b0;
	assign SDA_OE_N = !sda_low;
	assign SCL_OE_N = !scl_low;

	////////////////////////////////////////////////////////////////////////////
	// Bit timing: four quarter steps per bit, quarter = 4, 8, 16 or 32 cycles.

	assign quarter = `I2M_QTR_BASE << mode[`I2M_DIV_MSB:`I2M_DIV_LSB];
	// A slave holding the clock low delays the end of the high phase. The check sits in the
	// last quarter, so that the master's own release has passed the synchroniser by then.
	assign adv = (div_cnt == quarter - 6'h01) && !((q == 2'h3) && !scl_s);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			div_cnt <= 6'h00;
		else if ((state == ST_IDLE) || (div_cnt >= quarter - 6'h01))
			div_cnt <= 6'h00;
		else
			div_cnt <= div_cnt + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	assign last = (rx_got == ({1'b0, mode[`I2M_RCT_MSB:0]} + 6'h01));
	assign fin_ok = adv && (q == 2'h3) && (((state == ST_ACK_A) && !ack_bit && !work_addr[0] &&
		(tx_cnt == 3'h0)) || ((state == ST_ACK_T) && !ack_bit && (tx_cnt == 3'h0)) ||
		((state == ST_ACK_M) && last));
	assign tx_flush = adv && (q == 2'h3) && ((state == ST_ACK_A) || (state == ST_ACK_T)) &&
		ack_bit;
	assign tx_pop = adv && (q == 2'h3) && !ack_bit && (tx_cnt != 3'h0) &&
		(((state == ST_ACK_A) && !work_addr[0]) || (state == ST_ACK_T));
	assign rx_push = adv && (q == 2'h3) && (state == ST_RXB) && (bitn == 3'h7);
	assign take_pend = pending && ((state == ST_IDLE) || fin_ok);

	// Launch request: set by an address write while enabled, taken by the sequencer.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			pending <= 1'b0;
		else if (wr_go && w_lane && is_mapped(aw_addr) && (wr_idx == `I2M_IDX_ADDR) &&
			mode[`I2M_BIT_EN])
			pending <= 1'b1;
		else if (take_pend)
			pending <= 1'b0;
	end

	// Frame sequencing; quarter 0 changes data with the clock low.
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state <= ST_IDLE;
			q <= 2'h0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			work_addr <= `I2M_RST_REG;
			shreg <= 8'h00;
			bitn <= 3'h0;
			ack_bit <= 1'b0;
			rx_got <= 6'h00;
		end
		else if (state == ST_IDLE)
		begin
			q <= 2'h0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			if (pending)
			begin
				state <= ST_START;
				work_addr <= addr_reg;
			end
		end
		else if (adv)
		begin
			q <= q + 2'h1;
			if (q == 2'h1)
				scl_low <= 1'b0;
			if ((q == 2'h3) && (state != ST_STOP))
				scl_low <= 1'b1;
			unique case (state)
				ST_START, ST_RSTART:
				begin
					// Data falls while the clock is high.
					if (q == 2'h0)
						sda_low <= 1'b0;
					if (q == 2'h2)
						sda_low <= 1'b1;
					if (q == 2'h3)
					begin
						state <= ST_ADDR;
						shreg <= work_addr;
						bitn <= 3'h0;
						rx_got <= 6'h00;
					end
				end
				ST_ADDR, ST_TXB:
				begin
					// Most significant bit first.
					if (q == 2'h0)
						sda_low <= !shreg[7];
					if (q == 2'h3)
					begin
						shreg <= {shreg[6:0], 1'b0};
						bitn <= bitn + 3'h1;
						if (bitn == 3'h7)
							state <= (state == ST_ADDR) ? ST_ACK_A : ST_ACK_T;
					end
				end
				ST_RXB:
				begin
					if (q == 2'h0)
						sda_low <= 1'b0;
					if (q == 2'h2)
						shreg <= {shreg[6:0], sda_s};
					if (q == 2'h3)
					begin
						bitn <= bitn + 3'h1;
						if (bitn == 3'h7)
						begin
							state <= ST_ACK_M;
							rx_got <= rx_got + 6'h01;
						end
					end
				end
				ST_ACK_A, ST_ACK_T:
				begin
					if (q == 2'h0)
						sda_low <= 1'b0;
					if (q == 2'h2)
						ack_bit <= sda_s;
					if (q == 2'h3)
					begin
						if (ack_bit)
							state <= ST_STOP;
						else if ((state == ST_ACK_A) && work_addr[0])
						begin
							state <= ST_RXB;
							bitn <= 3'h0;
						end
						else if (tx_cnt != 3'h0)
						begin
							state <= ST_TXB;
							shreg <= tx_mem[tx_rp];
							bitn <= 3'h0;
						end
						else if (pending)
						begin
							state <= ST_RSTART;
							work_addr <= addr_reg;
						end
						else
							state <= ST_STOP;
					end
				end
				ST_ACK_M:
				begin
					if (q == 2'h0)
						sda_low <= !last;
					if (q == 2'h3)
					begin
						bitn <= 3'h0;
						if (!last)
							state <= ST_RXB;
						else if (pending)
						begin
							state <= ST_RSTART;
							work_addr <= addr_reg;
						end
						else
							state <= ST_STOP;
					end
				end
				ST_STOP:
				begin
					// Data rises while the clock is high.
					if (q == 2'h0)
						sda_low <= 1'b1;
					if (q == 2'h2)
						sda_low <= 1'b0;
					if (q == 2'h3)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_addr_wr;
		wr_go && w_lane && (wr_idx == `I2M_IDX_ADDR) && mode[`I2M_BIT_EN] &&
			(state == ST_IDLE) && !pending;
	endsequence
	sequence s_nack;
		adv && (q == 2'h3) && ((state == ST_ACK_A) || (state == ST_ACK_T)) && ack_bit;
	endsequence

	property p_launch;
		@(posedge CLK) disable iff (RST) s_addr_wr |=> pending ##1 (state == ST_START);
	endproperty
	a_launch: assert property (p_launch) else $error("address write did not launch");
	property p_dir;
		@(posedge CLK) disable iff (RST) (state == ST_ADDR) && (bitn == 3'h7) && (q == 2'h0) &&
			adv |=> (sda_low == !work_addr[0]);
	endproperty
	a_dir: assert property (p_dir) else $error("wrong direction bit");
	property p_drain;
		@(posedge CLK) disable iff (RST) tx_pop && !tx_push |=>
			(tx_cnt == $past(tx_cnt) - 3'h1) && (state == ST_TXB);
	endproperty
	a_drain: assert property (p_drain) else $error("transmit FIFO not drained");
	property p_nack;
		@(posedge CLK) disable iff (RST) s_nack |=> flag[`I2M_BIT_NOACK] &&
			(tx_cnt <= 3'h1) && (state == ST_STOP);
	endproperty
	a_nack: assert property (p_nack) else $error("missing acknowledge not handled");
	property p_rxp;
		@(posedge CLK) disable iff (RST) (rx_cnt != 3'h0) |=> flag[`I2M_BIT_RXP];
	endproperty
	a_rxp: assert property (p_rxp) else $error("receive flag not set");
	property p_txe;
		@(posedge CLK) disable iff (RST) (tx_cnt == 3'h0) |=> flag[`I2M_BIT_TXE];
	endproperty
	a_txe: assert property (p_txe) else $error("transmit flag not set");
	property p_acc;
		@(posedge CLK) disable iff (RST) acc_ev |=> flag[`I2M_BIT_ACC] &&
			($changed(tx_wp) || ($past(tx_cnt) == `I2M_FIFO_FULL));
	endproperty
	a_acc: assert property (p_acc) else $error("access error not flagged");
	property p_txw;
		@(posedge CLK) disable iff (RST) tx_try && (tx_cnt == `I2M_FIFO_FULL) && !tx_pop &&
			!tx_flush |=> flag[`I2M_BIT_TXW] && (tx_cnt == `I2M_FIFO_FULL);
	endproperty
	a_txw: assert property (p_txw) else $error("overfill not flagged");
	property p_mack;
		@(posedge CLK) disable iff (RST) (state == ST_ACK_M) && (q == 2'h2) |->
			(sda_low == !last) && !scl_low;
	endproperty
	a_mack: assert property (p_mack) else $error("master acknowledge wrong");
	property p_rstart;
		@(posedge CLK) disable iff (RST) fin_ok && pending |=> (state == ST_RSTART);
	endproperty
	a_rstart: assert property (p_rstart) else $error("no repeated start");
	property p_frame;
		@(posedge CLK) disable iff (RST) $changed(sda_low) && !scl_low && !$past(scl_low) |->
			(state == ST_START) || (state == ST_RSTART) || (state == ST_STOP);
	endproperty
	a_frame: assert property (p_frame) else $error("data changed with clock high");

endmodule

// ==== testbench/i2m_slave_model.sv ====
/*
 Behavioural two-wire target that acknowledges one address.
 Assumes pull-ups on both lines and that the master makes the clock.
*/
module i2m_slave_model
#(
	parameter logic [6:0] OWN_ADDR = 7'h2A // Address this target answers.
)
(
	input wire logic scl, // Clock line level.
	input wire logic sda, // Data line level.
	output logic pull // High while this target pulls data low.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] shift = 8'h00; // Incoming bits, first bit ends at the top.
	logic [7:0] data_out = 8'hC5; // Next byte sent on a read.
	logic [7:0] got[$]; // Bytes written to this target.
	logic acks[$]; // Master acknowledge levels seen on reads.
	int bit_no = 0; // Bit within a byte; 8 is the acknowledge bit.
	logic active = 1'b0; // Inside a frame.
	logic first = 1'b0; // Address byte in progress.
	logic rd = 1'b0; // Current frame reads from this target.
	logic match = 1'b0; // Addressed and still willing to answer.
	initial pull = 1'b0;
	// A data fall with the clock high opens a frame, a rise closes it.
	always @(sda)
		if (scl === 1'b1)
		begin
			active = !sda;
			first = 1'b1;
			bit_no = 0;
			pull = 1'b0;
		end
	// Sample on the clock rise, as the line only changes while low.
	always @(posedge scl)
		if (active)
		begin
			if (bit_no < 8)
				shift = {shift[6:0], sda};
			else if (rd && !first)
				acks.push_back(sda);
			if (bit_no == 7 && first)
			begin
				match = (shift[7:1] == OWN_ADDR);
				rd = shift[0];
			end
			if (bit_no == 7 && !first && !rd && match)
				got.push_back(shift);
			if (bit_no == 8 && rd && !first)
				data_out = data_out + 8'h11;
			if (bit_no == 8 && rd && !first && sda)
				match = 1'b0; // A refusal ends our sending so the stop can pass.
			if (bit_no == 8)
				first = 1'b0;
			bit_no = (bit_no == 8) ? 0 : bit_no + 1;
		end
	// Change the line only just after the clock falls.
	always @(negedge scl)
		if (active)
		begin
			if (bit_no == 8)
				pull = match && (first || !rd);
			else
				pull = match && rd && !first && !data_out[7 - bit_no];
		end
endmodule

// ==== testbench/test_i2c_master_addr_status.sv ====
/*
 Self-checking bench: register tasks over the register bus, one target.
 Assumes the map header and a pull-up on both bus lines.
*/
`include "i2m_map.svh"
module test_i2c_master_addr_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic ARVALID = 1'b0, RREADY = 1'b0, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic SDA_OE_N, SCL_OE_N, slave_pull;
	logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h00000000, RDATA;
	logic [3:0] WSTRB = 4'hF;
	logic [1:0] BRESP, RRESP, resp;
	logic [7:0] val;
	int miscompares = 0, total_checks = 0, cycles = 0;
	wire sda = SDA_OE_N & !slave_pull; // Wired AND with pull-up.
	wire scl = SCL_OE_N;
	always #4 CLK = ~CLK;
	i2m_top uut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.IRQ(IRQ), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(SDA_OE_N), .SCL_IN(scl), .SCL_OUT(),
		.SCL_OE_N(SCL_OE_N));
	i2m_slave_model part (.scl(scl), .sda(sda), .pull(slave_pull));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Offer address and data together, drop each when taken, wait for the answer.
	// Ready and valid are looked at on the falling edge, where they are settled.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic aw_ok, w_ok, b_ok;
		@(posedge CLK);
		AWADDR <= {2'h0, idx, 2'h0};
		WDATA <= {24'h000000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(negedge CLK);
			aw_ok = AWREADY;
			w_ok = WREADY;
			b_ok = BVALID;
			@(posedge CLK);
			if (aw_ok)
				AWVALID <= 1'b0;
			if (w_ok)
				WVALID <= 1'b0;
		end
		while (b_ok !== 1'b1);
		BREADY <= 1'b0;
	endtask
	// Read one register and keep data and response from the answering edge.
	task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge CLK);
		ARADDR <= {2'h0, idx, 2'h0};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(negedge CLK);
			ar_ok = ARREADY;
			r_ok = RVALID;
			d = RDATA[7:0];
			r = RRESP;
			@(posedge CLK);
			if (ar_ok)
				ARVALID <= 1'b0;
		end
		while (r_ok !== 1'b1);
		RREADY <= 1'b0;
	endtask
	task automatic expect_reg(input string what, input logic [7:0] idx, input logic [7:0] exp);
		rd(idx, val, resp);
		check(what, exp, val);
	endtask
	// Poll the busy flag until the frame has finished.
	task automatic wait_idle();
		val = 8'h80;
		for (int i = 0; i < 1000 && val[7] !== 1'b0; i++)
			rd(`I2M_IDX_STAT, val, resp);
		check("idle", 8'h00, val & 8'h80);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// A hang counts as a mismatch and ends the run.
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		expect_reg("status", `I2M_IDX_STAT, 8'h10);
		expect_reg("address", `I2M_IDX_ADDR, 8'h00);
		wr(`I2M_IDX_MODE, 8'h00);
		wr(`I2M_IDX_ADDR, 8'h54);
		expect_reg("idle", `I2M_IDX_STAT, 8'h10);
		for (int i = 1; i < 6; i++)
			wr(`I2M_IDX_TX, 8'(i * 17));
		expect_reg("full", `I2M_IDX_STAT, 8'h1D);
		wr(`I2M_IDX_MASK, 8'h01);
		check("irq", 8'h01, {7'h00, IRQ});
		wr(`I2M_IDX_STAT, 8'h00);
		expect_reg("cleared", `I2M_IDX_STAT, 8'h0C);
		check("irq", 8'h00, {7'h00, IRQ});
		wr(`I2M_IDX_MODE, 8'h80);
		wr(`I2M_IDX_ADDR, 8'h54);
		rd(`I2M_IDX_STAT, val, resp);
		check("busy", 8'h80, val & 8'h80);
		wait_idle();
		check("sent", 8'h04, 8'(part.got.size()));
		for (int i = 0; i < 4 && i < part.got.size(); i++)
			check("byte", 8'((i + 1) * 17), part.got[i]);
		expect_reg("drained", `I2M_IDX_STAT, 8'h10);
		wr(`I2M_IDX_MODE, 8'h81);
		wr(`I2M_IDX_ADDR, 8'h55);
		wait_idle();
		expect_reg("received", `I2M_IDX_STAT, 8'h38);
		check("acks", 8'h02, 8'(part.acks.size()));
		if (part.acks.size() == 2)
		begin
			check("ack", 8'h00, {7'h00, part.acks[0]});
			check("nack", 8'h01, {7'h00, part.acks[1]});
		end
		expect_reg("rx0", `I2M_IDX_RX, 8'hC5);
		expect_reg("rx1", `I2M_IDX_RX, 8'hD6);
		// Rewriting the address mid-frame chains a second read by a repeated start.
		wr(`I2M_IDX_ADDR, 8'h55);
		wr(`I2M_IDX_ADDR, 8'h55);
		wait_idle();
		check("restart acks", 8'h06, 8'(part.acks.size()));
		expect_reg("restart", `I2M_IDX_STAT, 8'h3C);
		// A buffer write and a buffer read committing in the same cycle.
		fork
			wr(`I2M_IDX_TX, 8'h66);
			begin
				@(posedge CLK);
				rd(`I2M_IDX_RX, val, resp);
			end
		join
		check("rx2", 8'hE7, val);
		rd(`I2M_IDX_STAT, val, resp);
		check("access", 8'h02, val & 8'h02);
		wr(`I2M_IDX_ADDR, 8'h20);
		wait_idle();
		rd(`I2M_IDX_STAT, val, resp);
		check("noack", 8'h42, val & 8'hCE);
		rd(8'h10, val, resp);
		check("unmapped", 8'h00, val);
		check("slverr", 8'h02, {6'h00, resp});
		complete_run();
	end
endmodule
